/* design/liu_channel_control.v */
// Contract
// - mute set and LOS: both data outputs low
// - mute clear: data passes during LOS
// - monitor bit selects receive monitor mode
// - bit 0 enables equalizer, resets 0
// - control at 0x06/0x0E/0x16, bits 7:6 zero
// - generator: 2^15-1 DS3/STS-1, 2^23-1 E3
// - enabled checker searches recovered data
// - one bit enables generator and checker
// - rail bit 0: negative pin flags errors
// - pattern replaces system transmit data
// - pattern test only in host mode
// - E3 bit chooses E3, else neighbour bit
`timescale 1ns/1ns
`include "liu_rx_prbs_regs.vh"

module liu_channel_control #(
  parameter CHANNELS = 3
) (
  input  wire                clock,
  input  wire                rst,
  input  wire                hostMode,
  input  wire [7:0]          regAddr,
  input  wire [7:0]          regWrData,
  input  wire                regWrite,
  input  wire                regRead,
  output reg  [7:0]          regRdData,
  input  wire [CHANNELS-1:0] rxPosIn,
  input  wire [CHANNELS-1:0] rxNegIn,
  input  wire [CHANNELS-1:0] lossOfSignal,
  input  wire [CHANNELS-1:0] tx_positive_data_in,
  input  wire [CHANNELS-1:0] tx_negative_data_in,
  output reg  [CHANNELS-1:0] rx_positive_data_out,
  output reg  [CHANNELS-1:0] rx_neg_or_violation_pin,
  output reg  [CHANNELS-1:0] txPosOut,
  output reg  [CHANNELS-1:0] txNegOut,
  output reg  [CHANNELS-1:0] equalizerEnable,
  output reg  [CHANNELS-1:0] monitorMode,
  output reg  [CHANNELS-1:0] e_rate_select,
  output reg  [CHANNELS-1:0] sonet_or_t_rate_select,
  output reg  [CHANNELS-1:0] remote_loop_select,
  output reg  [CHANNELS-1:0] local_loop_select,
  output reg  [CHANNELS-1:0] rail_format_select,
  output reg  [CHANNELS-1:0] pattern_test_enable,
  output reg  [CHANNELS-1:0] patternSynced
);

  wire [8*CHANNELS-1:0] readTerm;
  reg  [7:0]            next_regRdData;
  integer               k;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : chan
      reg  [5:0] ctrl;
      reg  [5:0] rxOpt;
      wire [7:0] ctrlAddr;
      wire [7:0] rxOptAddr;
      wire       testOn;
      wire       genBit;
      wire       errPulse;
      wire       lockBit;
      wire       muteNow;
      wire       ctrlHit;
      wire       rxOptHit;
      localparam integer CTRL_OFFSET  = `CTRL_BASE + ch * `CHANNEL_STRIDE;
      localparam integer RXOPT_OFFSET = `RXOPT_BASE + ch * `CHANNEL_STRIDE;

      //////////////////////////////////////////////////////////////////////
      // address decode for this channel
      assign ctrlAddr  = CTRL_OFFSET[7:0];
      assign rxOptAddr = RXOPT_OFFSET[7:0];
      assign ctrlHit   = regWrite && (regAddr == ctrlAddr);
      assign rxOptHit  = regWrite && (regAddr == rxOptAddr);

      //////////////////////////////////////////////////////////////////////
      // register writes; only low six bits are stored
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          ctrl  <= `CTRL_RESET;
          rxOpt <= `RXOPT_RESET;
        end else begin
          if (ctrlHit) begin
            ctrl <= regWrData[`REG_LIVE_BITS-1:0];
          end
          if (rxOptHit) begin
            rxOpt <= regWrData[`REG_LIVE_BITS-1:0];
          end
        end
      end

      //////////////////////////////////////////////////////////////////////
      // read terms, upper two bits always zero
      assign readTerm[8*ch +: 8] =
        (regAddr == ctrlAddr)  ? {2'b00, ctrl} :
        (regAddr == rxOptAddr) ? {2'b00, rxOpt} : 8'h00;

      //////////////////////////////////////////////////////////////////////
      // pattern test is gated by host mode
      assign testOn  = ctrl[`CTRL_PRBS_BIT] & hostMode;
      assign muteNow = rxOpt[`RXOPT_MUTE_BIT] & lossOfSignal[ch];

      prbs_engine engine (
        .clock      (clock),
        .rst        (rst),
        .enable     (testOn),
        .longMode   (ctrl[`CTRL_E3_BIT]),
        .rxBit      (rxPosIn[ch]),
        .txBit      (genBit),
        .errorPulse (errPulse),
        .synced     (lockBit)
      );

      //////////////////////////////////////////////////////////////////////
      // positive receive output; forced low while muted
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          rx_positive_data_out[ch] <= 1'b0;
        end else if (muteNow) begin
          rx_positive_data_out[ch] <= 1'b0;
        end else begin
          rx_positive_data_out[ch] <= rxPosIn[ch];
        end
      end

      //////////////////////////////////////////////////////////////////////
      // negative receive output; mute wins over the error indicator
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          rx_neg_or_violation_pin[ch] <= 1'b0;
        end else if (muteNow) begin
          rx_neg_or_violation_pin[ch] <= 1'b0;
        end else if (testOn && !ctrl[`CTRL_RAIL_BIT]) begin
          rx_neg_or_violation_pin[ch] <= errPulse;
        end else begin
          rx_neg_or_violation_pin[ch] <= rxNegIn[ch];
        end
      end

      //////////////////////////////////////////////////////////////////////
      // transmit path: pattern overrides system data
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          txPosOut[ch] <= 1'b0;
          txNegOut[ch] <= 1'b0;
        end else if (testOn) begin
          txPosOut[ch] <= genBit;
          txNegOut[ch] <= 1'b0;
        end else begin
          txPosOut[ch] <= tx_positive_data_in[ch];
          txNegOut[ch] <= tx_negative_data_in[ch];
        end
      end

      //////////////////////////////////////////////////////////////////////
      // receive options to the analog front end
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          equalizerEnable[ch] <= 1'b0;
          monitorMode[ch]     <= 1'b0;
        end else begin
          equalizerEnable[ch] <= rxOpt[`RXOPT_EQ_BIT];
          monitorMode[ch]     <= rxOpt[`RXOPT_MON_BIT];
        end
      end

      //////////////////////////////////////////////////////////////////////
      // rate selects; the E3 bit hides the neighbouring bit
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          e_rate_select[ch]          <= 1'b0;
          sonet_or_t_rate_select[ch] <= 1'b0;
        end else begin
          e_rate_select[ch]          <= ctrl[`CTRL_E3_BIT];
          sonet_or_t_rate_select[ch] <= ctrl[`CTRL_E3_BIT] ? 1'b0 : ctrl[`CTRL_STS_BIT];
        end
      end

      //////////////////////////////////////////////////////////////////////
      // loopback and rail format selects, plain copies of the bits
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          remote_loop_select[ch] <= 1'b0;
          local_loop_select[ch]  <= 1'b0;
          rail_format_select[ch] <= 1'b0;
        end else begin
          remote_loop_select[ch] <= ctrl[`CTRL_RLB_BIT];
          local_loop_select[ch]  <= ctrl[`CTRL_LLB_BIT];
          rail_format_select[ch] <= ctrl[`CTRL_RAIL_BIT];
        end
      end

      //////////////////////////////////////////////////////////////////////
      // pattern test status seen by the system side
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          pattern_test_enable[ch] <= 1'b0;
          patternSynced[ch]       <= 1'b0;
        end else begin
          pattern_test_enable[ch] <= testOn;
          patternSynced[ch]       <= lockBit;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  always @* begin
    next_regRdData = 8'h00;
    for (k = 0; k < CHANNELS; k = k + 1) begin
      next_regRdData = next_regRdData | readTerm[8*k +: 8];
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= next_regRdData;
    end
  end

endmodule

/* shared/liu_rx_prbs_regs.vh */
`ifndef LIU_RX_PRBS_REGS_VH
`define LIU_RX_PRBS_REGS_VH

// register offsets of channel 0 and spacing between channels
`define CTRL_BASE        8'h06
`define RXOPT_BASE       8'h05
`define CHANNEL_STRIDE   8'h08

// channel control fields
`define CTRL_RAIL_BIT    0
`define CTRL_STS_BIT     1
`define CTRL_E3_BIT      2
`define CTRL_LLB_BIT     3
`define CTRL_RLB_BIT     4
`define CTRL_PRBS_BIT    5
`define CTRL_RESET       6'h00

// receive options fields
`define RXOPT_EQ_BIT     0
`define RXOPT_MON_BIT    1
`define RXOPT_MUTE_BIT   2
`define RXOPT_CLKINV_BIT 3
`define RXOPT_ALOS_BIT   4
`define RXOPT_DLOS_BIT   5
`define RXOPT_RESET      6'h00

// writable width of both registers; bits 7:6 read as zero
`define REG_LIVE_BITS    6

// pattern checker: matching bits needed before errors are flagged
`define PRBS_SYNC_COUNT  6'h20
// taps of the two sequences
`define PRBS_SHORT_TAP_A 14
`define PRBS_SHORT_TAP_B 13
`define PRBS_LONG_TAP_A  22
`define PRBS_LONG_TAP_B  17
`define PRBS_SEED        23'h000001

`endif

/* design/prbs_engine.v */
`timescale 1ns/1ns
`include "liu_rx_prbs_regs.vh"

module prbs_engine (
  input  wire clock,
  input  wire rst,
  input  wire enable,
  input  wire longMode,
  input  wire rxBit,
  output reg  txBit,
  output reg  errorPulse,
  output reg  synced
);

  reg  [22:0] gen;
  reg  [22:0] chk;
  reg  [5:0]  goodCount;
  reg         lastMode;
  wire        genFeedback;
  wire        predicted;
  wire        mismatch;

  ////////////////////////////////////////////////////////////////////////////
  // feedback: 15-stage x^15+x^14+1, 23-stage x^23+x^18+1
  assign genFeedback = longMode ? (gen[`PRBS_LONG_TAP_A] ^ gen[`PRBS_LONG_TAP_B])
                                : (gen[`PRBS_SHORT_TAP_A] ^ gen[`PRBS_SHORT_TAP_B]);
  assign predicted   = longMode ? (chk[`PRBS_LONG_TAP_A] ^ chk[`PRBS_LONG_TAP_B])
                                : (chk[`PRBS_SHORT_TAP_A] ^ chk[`PRBS_SHORT_TAP_B]);
  assign mismatch    = rxBit ^ predicted;

  ////////////////////////////////////////////////////////////////////////////
  // generator; held at a nonzero seed while off to avoid lock-up
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      gen   <= `PRBS_SEED;
      txBit <= 1'b0;
    end else if (!enable) begin
      gen   <= `PRBS_SEED;
      txBit <= 1'b0;
    end else begin
      gen   <= {gen[21:0], genFeedback};
      txBit <= genFeedback;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checker: self-synchronising, flags errors only once locked
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      chk        <= 23'h000000;
      goodCount  <= 6'h00;
      synced     <= 1'b0;
      errorPulse <= 1'b0;
      lastMode   <= 1'b0;
    end else begin
      chk        <= {chk[21:0], rxBit};
      lastMode   <= longMode;
      errorPulse <= 1'b0;
      if (!enable || (lastMode != longMode)) begin
        goodCount <= 6'h00; // rate change forces a new search
        synced    <= 1'b0;
      end else if (!synced) begin
        if (mismatch) begin
          goodCount <= 6'h00;
        end else if (goodCount == `PRBS_SYNC_COUNT - 6'h01) begin
          synced <= 1'b1;
        end else begin
          goodCount <= goodCount + 6'h01;
        end
      end else begin
        errorPulse <= mismatch; // one pulse per mismatched bit, so one line error gives three
      end
    end
  end

endmodule

/* bench/liu_channel_checker.sv */
`timescale 1ns/1ns
module liu_channel_checker #(
  parameter CHANNELS = 3
) (
  input wire                clock,
  input wire                rst,
  input wire                hostMode,
  input wire [7:0]          regAddr,
  input wire [7:0]          regWrData,
  input wire                regWrite,
  input wire [CHANNELS-1:0] lossOfSignal,
  input wire [CHANNELS-1:0] rxPosIn,
  input wire [CHANNELS-1:0] rx_positive_data_out,
  input wire [CHANNELS-1:0] rx_neg_or_violation_pin,
  input wire [CHANNELS-1:0] txNegOut,
  input wire [CHANNELS-1:0] equalizerEnable,
  input wire [CHANNELS-1:0] monitorMode,
  input wire [CHANNELS-1:0] e_rate_select,
  input wire [CHANNELS-1:0] sonet_or_t_rate_select,
  input wire [CHANNELS-1:0] pattern_test_enable,
  input wire [CHANNELS-1:0] patternSynced
);
  reg mute0;
  // mirror of the channel 0 mute bit, followed from host writes
  always @(posedge clock or posedge rst) begin
    if (rst)
      mute0 <= 1'b0;
    else if (regWrite && regAddr == 8'h05)
      mute0 <= regWrData[2];
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_opt_write;
    regWrite && regAddr == 8'h05;
  endsequence
  sequence s_ctrl_write;
    regWrite && regAddr == 8'h06 && hostMode;
  endsequence
  a_mute_both_low: assert property (lossOfSignal[0] && mute0 |=>
    !rx_positive_data_out[0] && !rx_neg_or_violation_pin[0]) else $error("mute failed");
  a_data_passes: assert property (!lossOfSignal[0] |=>
    rx_positive_data_out[0] == $past(rxPosIn[0])) else $error("rx data lost");
  a_opt_bits: assert property (s_opt_write |=> ##1
    (equalizerEnable[0] == $past(regWrData[0], 2) && monitorMode[0] == $past(regWrData[1], 2)))
    else $error("option bits wrong");
  a_pattern_write: assert property (s_ctrl_write |=> ##1
    (pattern_test_enable[0] == $past(regWrData[5], 2))) else $error("pattern enable wrong");
  a_host_only: assert property (!hostMode |=> !pattern_test_enable[0])
    else $error("pattern on in pin mode");
  a_tx_override: assert property (pattern_test_enable[0] && $past(pattern_test_enable[0])
    |-> !txNegOut[0]) else $error("tx data not overridden");
  a_rate_exclusive: assert property (e_rate_select[0] |-> !sonet_or_t_rate_select[0])
    else $error("two rates selected");
  a_lock_needs_bits: assert property ($rose(patternSynced[0]) |->
    pattern_test_enable[0] && $past(pattern_test_enable[0], 30)) else $error("early lock");
endmodule

/* bench/system_side_model.sv */
`timescale 1ns/1ns
module system_side_model (
  input  wire       clock,
  input  wire       rst,
  input  wire       errorPin,
  input  wire       countEnable,
  output reg        txPos,
  output reg        txNeg,
  output reg  [7:0] errorCount
);
  // toggling transmit data, and a count of pattern error pulses
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      txPos <= 1'b0;
      txNeg <= 1'b0;
      errorCount <= 8'h00;
    end else begin
      txPos <= ~txPos;
      txNeg <= txPos;
      if (countEnable && errorPin)
        errorCount <= errorCount + 8'h01;
    end
  end
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
  localparam CHANNELS = 3;
  reg         clock, rst, hostMode, regWrite, regRead, loopOn, flip;
  reg  [7:0]  regAddr, regWrData;
  reg  [2:0]  rxPosDrv, rxNegIn, lossOfSignal;
  wire [7:0]  regRdData, errorCount;
  wire [2:0]  rxPosIn, rxPos, rxNeg, txPosOut, txNegOut, eqEn, monEn, eRate, tRate, patEn, sync;
  wire [2:0]  rlbSel, llbSel, railSel;
  wire        txPos, txNeg;
  integer     num_errors, comparisons, i;
  reg  [63:0] hist;
  // channel 0 may be looped from its transmit output, with one bit flipped
  assign rxPosIn = loopOn ? {rxPosDrv[2:1], txPosOut[0] ^ flip} : rxPosDrv;
  liu_channel_control #(.CHANNELS(CHANNELS)) DUT (.clock(clock), .rst(rst),
    .hostMode(hostMode), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .rxPosIn(rxPosIn), .rxNegIn(rxNegIn),
    .lossOfSignal(lossOfSignal), .tx_positive_data_in({3{txPos}}),
    .tx_negative_data_in({3{txNeg}}), .rx_positive_data_out(rxPos),
    .rx_neg_or_violation_pin(rxNeg), .txPosOut(txPosOut), .txNegOut(txNegOut),
    .equalizerEnable(eqEn), .monitorMode(monEn), .e_rate_select(eRate),
    .sonet_or_t_rate_select(tRate), .remote_loop_select(rlbSel), .local_loop_select(llbSel),
    .rail_format_select(railSel), .pattern_test_enable(patEn), .patternSynced(sync));
  system_side_model sys (.clock(clock), .rst(rst), .errorPin(rxNeg[0]),
    .countEnable(patEn[0]), .txPos(txPos), .txNeg(txNeg), .errorCount(errorCount));
  ////////////////////////////////////////////////////////////////////////////
  task tick; begin @(posedge clock); #1; end endtask
  task check(input string name, input [7:0] exp, input [7:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        $display("mismatch %s expected %h seen %h", name, exp, got);
        num_errors = num_errors + 1;
      end
    end
  endtask
  task finish_test;
    begin
      if (num_errors == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin regAddr = a; regWrData = d; regWrite = 1; tick; regWrite = 0; tick; end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin regAddr = a; regRead = 1; tick; regRead = 0; check("read", exp, regRdData); tick; end
  endtask
  // waits for checker lock under a bound
  task wait_sync;
    begin
      for (i = 0; i < 400 && sync[0] !== 1'b1; i = i + 1) tick;
      if (sync[0] !== 1'b1) begin num_errors = num_errors + 1; finish_test; end
    end
  endtask
  // each sent bit must be the sum of the two bits la and lb back
  task check_seq(input integer la, input integer lb);
    begin
      for (i = 0; i < 64; i = i + 1) begin hist = {hist[62:0], txPosOut[0]}; tick; end
      for (i = 0; i < 64 - la; i = i + 1)
        check("pattern", {7'h00, hist[i + la] ^ hist[i + lb]}, {7'h00, hist[i]});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      rd(8'h06, 8'h00);
      rd(8'h0e, 8'h00);
      rd(8'h05, 8'h00);
      check("eq", 8'h00, {5'h00, eqEn});
    end
  endtask
  task t_ctrl;
    begin
      wr(8'h06, 8'hff);
      rd(8'h06, 8'h3f);
      check("rate", 8'h01, {6'h00, tRate[0], eRate[0]});
      check("loops", 8'h07, {5'h00, rlbSel[0], llbSel[0], railSel[0]});
      wr(8'h0e, 8'hff);
      rd(8'h0e, 8'h3f);
      wr(8'h07, 8'hff);
      rd(8'h07, 8'h00);
      wr(8'h06, 8'h02);
      check("rate", 8'h02, {6'h00, tRate[0], eRate[0]});
      check("loops", 8'h00, {5'h00, rlbSel[0], llbSel[0], railSel[0]});
      wr(8'h06, 8'h00);
      wr(8'h0e, 8'h00);
    end
  endtask
  task t_rxopt;
    begin
      wr(8'h05, 8'h07);
      check("opt", 8'h03, {6'h00, monEn[0], eqEn[0]});
      wr(8'h0d, 8'h01);
      wr(8'h15, 8'h01);
      check("eq", 8'h07, {5'h00, eqEn});
      lossOfSignal = 3'b011; rxPosDrv = 3'b111; rxNegIn = 3'b111; tick; tick;
      check("mute", 8'h01, {6'h00, rxNeg[0] | rxPos[0], rxPos[1]});
      wr(8'h05, 8'h01);
      check("nomute", 8'h03, {6'h00, rxNeg[0], rxPos[0]});
      lossOfSignal = 3'b000; rxPosDrv = 3'b000; rxNegIn = 3'b000;
    end
  endtask
  task t_prbs;
    begin
      loopOn = 1;
      wr(8'h06, 8'h20);
      check("enable", 8'h01, {7'h00, patEn[0]});
      wait_sync;
      check("txneg", 8'h00, {7'h00, txNegOut[0]});
      check_seq(15, 14);
      check("noerr", 8'h00, errorCount);
      flip = 1; tick; flip = 0; repeat (6) tick;
      check("err", 8'h01, {7'h00, errorCount >= 1 && errorCount <= 3});
      wr(8'h06, 8'h24); repeat (40) tick;
      wait_sync;
      check_seq(23, 18);
      hostMode = 0; tick; tick;
      check("pinmode", 8'h00, {7'h00, patEn[0]});
      hostMode = 1; tick; tick;
      wr(8'h06, 8'h00); loopOn = 0;
      check("disable", 8'h00, {7'h00, patEn[0]});
      check("txpass", {7'h00, txNeg}, {7'h00, txPosOut[0]});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin clock = 0; forever #20 clock = ~clock; end
  initial begin
    rst = 1; hostMode = 1; regAddr = 0; regWrData = 0; regWrite = 0; regRead = 0;
    loopOn = 0; flip = 0; rxPosDrv = 0; rxNegIn = 0; lossOfSignal = 0;
    num_errors = 0; comparisons = 0; hist = 0;
    repeat (4) @(posedge clock);
    #1 rst = 0;
    t_reset; t_ctrl; t_rxopt; t_prbs;
    finish_test;
  end
endmodule
bind liu_channel_control liu_channel_checker #(.CHANNELS(CHANNELS)) u_chk (.clock(clock),
  .rst(rst), .hostMode(hostMode), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .lossOfSignal(lossOfSignal), .rxPosIn(rxPosIn),
  .rx_positive_data_out(rx_positive_data_out), .rx_neg_or_violation_pin(rx_neg_or_violation_pin),
  .txNegOut(txNegOut), .equalizerEnable(equalizerEnable), .monitorMode(monitorMode),
  .e_rate_select(e_rate_select), .sonet_or_t_rate_select(sonet_or_t_rate_select),
  .pattern_test_enable(pattern_test_enable), .patternSynced(patternSynced));
